// ### pkg/mode_regs_pkg.sv
package mode_regs_pkg;
    // mode register addresses
    localparam logic [5:0] ADDR_CAL_RESET = 6'h0A;
    localparam logic [5:0] ADDR_TERM      = 6'h0B;
    localparam logic [5:0] ADDR_CA_REF    = 6'h0C;
    localparam logic [5:0] ADDR_SETPOINT  = 6'h0D;
    localparam logic [5:0] ADDR_TEST      = 6'h09;
    // field positions
    localparam int CAL_TRIG_BIT     = 0;
    localparam int DQ_TERM_LSB      = 0;
    localparam int CA_TERM_LSB      = 4;
    localparam int NT_TERM_LO_BIT   = 3;
    localparam int NT_TERM_HI_BIT   = 7;
    localparam int REF_LEVEL_LSB    = 0;
    localparam int REF_RANGE_BIT    = 6;
    localparam int SP_ACCESS_BIT    = 6;
    localparam int SP_ACTIVE_BIT    = 7;
    // codes and reset values
    localparam logic [2:0] TERM_RESERVED   = 3'h7;
    localparam logic [2:0] TERM_RST        = 3'h0;
    localparam logic [1:0] NT_TERM_RST     = 2'h0;
    localparam logic [5:0] REF_LEVEL_MAX   = 6'h32;
    localparam logic [5:0] REF_LEVEL_RST   = 6'h0D;
    localparam logic       REF_RANGE_RST   = 1'b1;
    localparam logic [7:0] SETPOINT_RST    = 8'h00;
    localparam logic [7:0] CA_REF_RMASK    = 8'h7F;
endpackage

// ### rtl/mode_regs.sv
`timescale 1ns/1ns
`default_nettype none
module mode_regs #(
    parameter bit NT_TERM_SUPPORTED = 1'b1
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    // mode register command port
    input  wire logic        mrw_i,
    input  wire logic        mrr_i,
    input  wire logic [5:0]  mr_addr_i,
    input  wire logic [7:0]  mr_wdata_i,
    output logic      [15:0] mr_rdata_o,
    output logic             mr_rvalid_o,
    // calibration
    input  wire logic        cal_pin_grounded_i,
    input  wire logic        cal_start_cmd_i,
    output logic             cal_start_o,
    output logic             impedance_cal_default_trigger_o,
    // active settings
    output logic      [2:0]  data_lane_termination_o,
    output logic      [1:0]  nontarget_data_termination_o,
    output logic      [2:0]  command_lane_termination_o,
    output logic      [5:0]  command_reference_level_o,
    output logic             command_reference_range_o,
    output logic             setpoint_active_select_o,
    output logic             setpoint_access_select_o,
    output logic             mask_disable_o,
    output logic             refresh_rate_option_o,
    output logic             reference_fast_settle_o,
    output logic             reference_output_o,
    output logic             read_preamble_training_o,
    output logic             command_bus_training_o
);

////////////////////////////////////////////////////////////////////////////////
// strap sync and decode

    logic       strap_meta_ff;
    logic       strap_sync_ff;
    logic [2:0] dq_term_ff   [2];
    logic [1:0] nt_term_ff   [2];
    logic [2:0] ca_term_ff   [2];
    logic [5:0] ref_level_ff [2];
    logic       ref_range_ff [2];
    logic [7:0] setpoint_ff;

    wire        acc_sel     = setpoint_ff[mode_regs_pkg::SP_ACCESS_BIT];
    wire        act_sel     = setpoint_ff[mode_regs_pkg::SP_ACTIVE_BIT];
    wire        wr_cal      = mrw_i && (mr_addr_i == mode_regs_pkg::ADDR_CAL_RESET);
    wire        wr_term     = mrw_i && (mr_addr_i == mode_regs_pkg::ADDR_TERM);
    wire        wr_ref      = mrw_i && (mr_addr_i == mode_regs_pkg::ADDR_CA_REF);
    wire        wr_sp       = mrw_i && (mr_addr_i == mode_regs_pkg::ADDR_SETPOINT);
    wire        rd_ref      = mrr_i && (mr_addr_i == mode_regs_pkg::ADDR_CA_REF);
    wire [2:0]  wdq         = mr_wdata_i[mode_regs_pkg::DQ_TERM_LSB +: 3];
    wire [2:0]  wca         = mr_wdata_i[mode_regs_pkg::CA_TERM_LSB +: 3];
    wire [1:0]  wnt         = {mr_wdata_i[mode_regs_pkg::NT_TERM_HI_BIT],
                               mr_wdata_i[mode_regs_pkg::NT_TERM_LO_BIT]};
    wire [5:0]  wlvl        = mr_wdata_i[mode_regs_pkg::REF_LEVEL_LSB +: 6];
    // reserved codes leave the old value in place
    wire        dq_ok       = (wdq != mode_regs_pkg::TERM_RESERVED);
    wire        ca_ok       = (wca != mode_regs_pkg::TERM_RESERVED);
    wire        lvl_ok      = (wlvl <= mode_regs_pkg::REF_LEVEL_MAX);
    wire [7:0]  ref_rd_word = {1'b0, ref_range_ff[acc_sel], ref_level_ff[acc_sel]}
                              & mode_regs_pkg::CA_REF_RMASK;
    wire [15:0] nxt_rdata   = rd_ref ? {8'h00, ref_rd_word} : 16'h0000;

    always_ff @(posedge ref_clk_i) begin
        strap_meta_ff <= cal_pin_grounded_i;
        strap_sync_ff <= strap_meta_ff;
    end

////////////////////////////////////////////////////////////////////////////////
// per set-point copies

    genvar sp;
    generate
        for (sp = 0; sp < 2; sp++) begin : g_copy
            wire hit = (acc_sel == 1'(sp));
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i) begin
                    dq_term_ff[sp]   <= mode_regs_pkg::TERM_RST;
                    nt_term_ff[sp]   <= mode_regs_pkg::NT_TERM_RST;
                    ca_term_ff[sp]   <= mode_regs_pkg::TERM_RST;
                    ref_level_ff[sp] <= mode_regs_pkg::REF_LEVEL_RST;
                    ref_range_ff[sp] <= mode_regs_pkg::REF_RANGE_RST;
                end else begin
                    if (wr_term && hit && dq_ok) begin
                        dq_term_ff[sp] <= wdq;
                    end
                    if (wr_term && hit && NT_TERM_SUPPORTED) begin
                        nt_term_ff[sp] <= wnt;
                    end
                    if (wr_term && hit && ca_ok) begin
                        ca_term_ff[sp] <= wca;
                    end
                    if (wr_ref && hit && lvl_ok) begin
                        ref_level_ff[sp] <= wlvl;
                    end
                    if (wr_ref && hit) begin
                        ref_range_ff[sp] <= mr_wdata_i[mode_regs_pkg::REF_RANGE_BIT];
                    end
                end
            end
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// control register and outputs

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            setpoint_ff                     <= mode_regs_pkg::SETPOINT_RST;
            mr_rdata_o                      <= 16'h0000;
            mr_rvalid_o                     <= 1'b0;
            cal_start_o                     <= 1'b0;
            impedance_cal_default_trigger_o <= 1'b0;
            data_lane_termination_o         <= mode_regs_pkg::TERM_RST;
            nontarget_data_termination_o    <= mode_regs_pkg::NT_TERM_RST;
            command_lane_termination_o      <= mode_regs_pkg::TERM_RST;
            command_reference_level_o       <= mode_regs_pkg::REF_LEVEL_RST;
            command_reference_range_o       <= mode_regs_pkg::REF_RANGE_RST;
        end else begin
            if (wr_sp) begin
                setpoint_ff <= mr_wdata_i;
            end
            // write-only addresses answer zero and keep their state
            mr_rdata_o  <= nxt_rdata;
            mr_rvalid_o <= mrr_i;
            impedance_cal_default_trigger_o <= wr_cal
                && mr_wdata_i[mode_regs_pkg::CAL_TRIG_BIT];
            cal_start_o <= cal_start_cmd_i && !strap_sync_ff;
            data_lane_termination_o      <= dq_term_ff[act_sel];
            nontarget_data_termination_o <= nt_term_ff[act_sel];
            command_lane_termination_o   <= ca_term_ff[act_sel];
            command_reference_level_o    <= ref_level_ff[act_sel];
            command_reference_range_o    <= ref_range_ff[act_sel];
        end
    end

    assign setpoint_active_select_o = setpoint_ff[7];
    assign setpoint_access_select_o = setpoint_ff[6];
    assign mask_disable_o           = setpoint_ff[5];
    assign refresh_rate_option_o    = setpoint_ff[4];
    assign reference_fast_settle_o  = setpoint_ff[3];
    assign reference_output_o       = setpoint_ff[2];
    assign read_preamble_training_o = setpoint_ff[1];
    assign command_bus_training_o   = setpoint_ff[0];

////////////////////////////////////////////////////////////////////////////////
// checks

    ref_read_lane_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        mrr_i && !rd_ref |=> mr_rdata_o == 16'h0000)
        else $error("non-reference read returned data");
    ref_read_rsv_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        1'b1 |=> mr_rdata_o[15:7] == 9'h000)
        else $error("reserved read bits nonzero");
    cal_ignore_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        strap_sync_ff |=> !cal_start_o)
        else $error("calibration command passed with grounded pin");
    cal_trig_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_cal && mr_wdata_i[0] |=> impedance_cal_default_trigger_o)
        else $error("default calibration trigger missed");
    term_rsv_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_term && wdq == 3'h7 |=> $stable(dq_term_ff[acc_sel]))
        else $error("reserved termination code stored");
    ca_rsv_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_term && wca == 3'h7 |=> $stable(ca_term_ff[acc_sel]))
        else $error("reserved command termination code stored");
    inactive_copy_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_ref && acc_sel != act_sel && !wr_sp |=> ##1
        $stable(command_reference_level_o))
        else $error("inactive copy disturbed operation");
    ref_write_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_ref && !wr_sp |=> ref_range_ff[acc_sel] == $past(mr_wdata_i[6]))
        else $error("range write did not reach access copy");
    level_max_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        1'b1 |-> ref_level_ff[0] <= 6'h32 && ref_level_ff[1] <= 6'h32)
        else $error("reserved reference level held");
endmodule
`default_nettype wire

// ### test/mr_controller_model.sv
`timescale 1ns/1ns
`default_nettype none
module mr_controller_model (
    // clock
    input  wire logic        ref_clk_i,
    // mode register command port
    output logic             mrw_o,
    output logic             mrr_o,
    output logic      [5:0]  addr_o,
    output logic      [7:0]  wdata_o,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i
);
    initial begin
        mrw_o   = 1'b0;
        mrr_o   = 1'b0;
        addr_o  = 6'h00;
        wdata_o = 8'h00;
    end
    // strobe stands for exactly one sampling edge; operands scrambled afterwards
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        addr_o  = a;
        wdata_o = d;
        mrw_o   = 1'b1;
        @(posedge ref_clk_i);
        #1;
        mrw_o   = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
    endtask
    // answer is registered, so it is taken in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic v);
        @(posedge ref_clk_i);
        #1;
        addr_o = a;
        mrr_o  = 1'b1;
        @(posedge ref_clk_i);
        #1;
        mrr_o  = 1'b0;
        addr_o = ~a;
        d      = rdata_i;
        v      = rvalid_i;
    endtask
endmodule
`default_nettype wire

// ### test/tb_dram_mode_regs_zq_odt_vref.sv
`timescale 1ns/1ns
`default_nettype none
module tb_dram_mode_regs_zq_odt_vref;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, mrw, mrr, rvalid, grounded = 1'b0, cmd = 1'b0;
    logic cal_start, trig;
    logic [5:0] addr, level;
    logic [7:0] wdata;
    logic [15:0] rdata;
    logic [2:0] dq, ca;
    logic [1:0] nt;
    logic range;
    // one 8-bit net for all control bit outputs, each bit driven by its own single output
    wire  [7:0] ctl;
    int err_count = 0, n_tests = 0, n_trig = 0, n_cal = 0, cycles = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    mr_controller_model ctrl_model_i (.ref_clk_i(ref_clk_i), .mrw_o(mrw), .mrr_o(mrr),
        .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
    mode_regs mode_regs_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .mrw_i(mrw),
        .mrr_i(mrr), .mr_addr_i(addr), .mr_wdata_i(wdata), .mr_rdata_o(rdata),
        .mr_rvalid_o(rvalid), .cal_pin_grounded_i(grounded), .cal_start_cmd_i(cmd),
        .cal_start_o(cal_start), .impedance_cal_default_trigger_o(trig),
        .data_lane_termination_o(dq), .nontarget_data_termination_o(nt),
        .command_lane_termination_o(ca), .command_reference_level_o(level),
        .command_reference_range_o(range), .setpoint_active_select_o(ctl[7]),
        .setpoint_access_select_o(ctl[6]), .mask_disable_o(ctl[5]),
        .refresh_rate_option_o(ctl[4]), .reference_fast_settle_o(ctl[3]),
        .reference_output_o(ctl[2]), .read_preamble_training_o(ctl[1]),
        .command_bus_training_o(ctl[0]));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // pulses counted here so that a stuck trigger shows as an extra count
    always @(posedge ref_clk_i) begin
        n_trig = n_trig + (trig === 1'b1);
        n_cal  = n_cal + (cal_start === 1'b1);
        cycles = cycles + 1;
        if (cycles > 3000) begin
            err_count = err_count + 1;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        ctrl_model_i.rd(a, d, v);
        chk("read data", d, exp);
        chk("read valid", {15'h0000, v}, 16'h0001);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        ctrl_model_i.wr(a, d);
        tick(2);
    endtask
    task automatic cal_pulse();
        tick(1);
        cmd = 1'b1;
        tick(1);
        cmd = 1'b0;
        tick(3);
    endtask
    task automatic chk_act(input logic [7:0] term, input logic [6:0] ref_word);
        chk("termination", {8'h00, dq, nt, ca}, {8'h00, term});
        chk("reference", {9'h000, range, level}, {9'h000, ref_word});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(5);
        sys_rst_i = 1'b0;
        chk_act(8'h00, 7'h4D);
        chk("control", {8'h00, ctl}, 16'h0000);
        rchk(6'h0C, 16'h004D);
        wr(6'h0B, 8'hAB);
        chk_act(8'h7A, 7'h4D);
        wr(6'h0B, 8'h77);
        chk_act(8'h62, 7'h4D);
        rchk(6'h0B, 16'h0000);
        wr(6'h0C, 8'h4A);
        chk_act(8'h62, 7'h4A);
        wr(6'h0C, 8'h3F);
        chk_act(8'h62, 7'h0A);
        wr(6'h0C, 8'hB2);
        rchk(6'h0C, 16'h0032);
        wr(6'h0D, 8'h40);
        chk("control", {8'h00, ctl}, 16'h0040);
        wr(6'h0C, 8'h45);
        wr(6'h0B, 8'h0A);
        chk_act(8'h62, 7'h32);
        rchk(6'h0C, 16'h0045);
        wr(6'h0D, 8'h80);
        chk_act(8'h48, 7'h45);
        rchk(6'h0C, 16'h0032);
        for (int i = 0; i < 8; i++) begin
            wr(6'h0D, 8'h01 << i);
            chk("control bit", {8'h00, ctl}, 16'h0001 << i);
        end
        wr(6'h0A, 8'h01);
        chk("default trigger", n_trig[15:0], 16'h0001);
        rchk(6'h0A, 16'h0000);
        tick(3);
        chk("default trigger", n_trig[15:0], 16'h0001);
        cal_pulse();
        chk("cal start", n_cal[15:0], 16'h0001);
        grounded = 1'b1;
        tick(3);
        cal_pulse();
        chk("cal start", n_cal[15:0], 16'h0001);
        wr(6'h09, 8'h00);
        rchk(6'h09, 16'h0000);
        rchk(6'h0D, 16'h0000);
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i = 1'b0;
        chk_act(8'h00, 7'h4D);
        conclude();
    end
endmodule
`default_nettype wire
